/* logic/addr_counter.sv */
// Read address counter: loads a start address, steps once per byte.
// Assumes load and step are never raised together.
`default_nettype none

module addr_counter
	import mio_read_pkg::*;
#(
	parameter int ADDR_BITS = 23
) (
	// Clock and reset
	input  wire logic   clock,
	input  wire logic   rstn,
	// Counter side of the carrier
	addr_step_if.counter aif
);
	localparam logic [ADDR_BITS-1:0] ADDR_MAX = '1;

	// The counter is exactly as wide as the array, so stepping past the
	// top address rolls back to zero.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			aif.addr <= '0;
		end else if (aif.load) begin
			aif.addr <= aif.load_value;
		end else if (aif.step) begin
			aif.addr <= ADDR_BITS'(aif.addr + 1'b1);
		end
	end

	a_addr_wrap_zero: assert property (@(posedge clock) disable iff (!rstn)
		aif.step && !aif.load && aif.addr == ADDR_MAX |=> aif.addr == '0)
		else $error("address did not roll over to zero");

	a_addr_step_one: assert property (@(posedge clock) disable iff (!rstn)
		aif.step && !aif.load && aif.addr != ADDR_MAX
		|=> aif.addr == ADDR_BITS'($past(aif.addr) + 1'b1))
		else $error("address did not advance by one byte");
endmodule : addr_counter

`default_nettype wire

/* logic/addr_step_if.sv */
// Carrier between the read sequencer and its address counter.
// Assumes both ends run on the same clock.
`default_nettype none

interface addr_step_if #(
	parameter int ADDR_BITS = 23
);
	logic                 load;
	logic [ADDR_BITS-1:0] load_value;
	logic                 step;
	logic [ADDR_BITS-1:0] addr;

	modport owner   (output load, output load_value, output step, input addr);
	modport counter (input load, input load_value, input step, output addr);
endinterface : addr_step_if

`default_nettype wire

/* logic/mio_read_pkg.sv */
// Constants and types shared by the multi-lane flash read front end.
// Assumes a single system clock domain; pins are synchronised before use.
`default_nettype none

package mio_read_pkg;

	// ---------------------------------------------------------------
	// Instruction codes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_QUAD_OUT      = 8'h6b;
	localparam logic [7:0] OP_QUAD_OUT_LONG = 8'h6c;
	localparam logic [7:0] OP_DUAL          = 8'hbb;
	localparam logic [7:0] OP_DUAL_LONG     = 8'hbc;
	localparam logic [7:0] OP_QUAD          = 8'heb;
	localparam logic [7:0] OP_QUAD_LONG     = 8'hec;

	// ---------------------------------------------------------------
	// Field sizes and codes
	// ---------------------------------------------------------------
	localparam logic [5:0] OPCODE_BITS    = 6'h08;
	localparam logic [5:0] MODE_BITS      = 6'h08;
	localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
	localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
	localparam logic [3:0] BYTE_BITS      = 4'h8;
	localparam logic [3:0] CONT_NIBBLE    = 4'ha;
	localparam logic [2:0] LANES_SINGLE   = 3'h1;
	localparam logic [2:0] LANES_DUAL     = 3'h2;
	localparam logic [2:0] LANES_QUAD     = 3'h4;
	localparam logic [3:0] OE_OFF         = 4'hf;
	localparam logic [3:0] OE_DUAL        = 4'hc;
	localparam logic [3:0] OE_QUAD        = 4'h0;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
	} phase_t;

	typedef enum logic [1:0] {RD_QUAD_OUT, RD_DUAL, RD_QUAD} read_kind_t;

endpackage : mio_read_pkg

`default_nettype wire

/* logic/multi_io_flash_read.sv */
// Command front end of a serial flash for quad-output, dual-lane and quad-lane reads.
// Assumes SCK high and low each last at least three clocks, and mem_rdata is valid
// one clock after mem_addr changes.
`default_nettype none

module multi_io_flash_read
	import mio_read_pkg::*;
#(
	parameter int ARRAY_ADDR_BITS = 23
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rstn,
	// Serial pins
	input  wire logic                       sck,
	input  wire logic                       cs_n,
	input  wire logic [3:0]                 data_lanes_in,
	output logic      [3:0]                 data_lanes_out,
	output logic      [3:0]                 data_lanes_oe_n,
	// Configuration bits
	input  wire logic                       address_length_bit,
	input  wire logic                       quad_enable_bit,
	input  wire logic                       quad_peripheral_enable_bit,
	input  wire logic                       quad_peripheral_mode_active,
	input  wire logic [3:0]                 latency_code_field,
	input  wire logic                       mode_reset_pulse,
	// Array read port
	output logic      [ARRAY_ADDR_BITS-1:0] mem_addr,
	input  wire logic [7:0]                 mem_rdata,
	// Status
	output logic                            continuous_mode,
	output logic                            read_active
);
	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (ARRAY_ADDR_BITS < 1 || ARRAY_ADDR_BITS > 32) begin : g_bad_width
		$error("ARRAY_ADDR_BITS must lie between 1 and 32");
	end

	// ---------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ---------------------------------------------------------------
	logic [5:0] pins_s;
	logic       sck_prev;
	logic       cs_prev;

	pin_sync #(.WIDTH(6), .RESET_VALUE(6'h10)) u_pin_sync (
		.clock (clock),
		.rstn  (rstn),
		.pin   ({sck, cs_n, data_lanes_in}),
		.q     (pins_s)
	);

	wire       sck_s    = pins_s[5];
	wire       cs_s     = pins_s[4];
	wire [3:0] io_s     = pins_s[3:0];
	wire       sck_rise = sck_s && !sck_prev && !cs_s;
	wire       sck_fall = !sck_s && sck_prev && !cs_s;
	wire       cs_rise  = cs_s && !cs_prev;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sck_prev <= 1'b0;
			cs_prev  <= 1'b1;
		end else begin
			sck_prev <= sck_s;
			cs_prev  <= cs_s;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer state
	// ---------------------------------------------------------------
	phase_t     state,       next_state;
	read_kind_t kind,        next_kind;
	read_kind_t cont_kind;
	logic [5:0] bit_cnt,     next_bit_cnt;
	logic [3:0] dcnt,        next_dcnt;
	logic       long_addr,   next_long;
	logic       pending,     next_pending;
	logic       mode_done,   next_mode_done;
	logic       cont;
	logic [31:0] shift;
	logic [7:0] out_sh;
	logic [3:0] out_left;

	// ---------------------------------------------------------------
	// Input lane selection and decode
	// ---------------------------------------------------------------
	wire [2:0] in_width = (state == ST_CMD) ?
		(quad_peripheral_mode_active ? LANES_QUAD : LANES_SINGLE) :
		(kind == RD_DUAL) ? LANES_DUAL :
		(kind == RD_QUAD) ? LANES_QUAD : LANES_SINGLE;

	// New bits enter at the bottom, so the first bit ends up most significant.
	wire [31:0] shift_next = (in_width == LANES_QUAD) ? {shift[27:0], io_s} :
		(in_width == LANES_DUAL) ? {shift[29:0], io_s[1:0]} :
		{shift[30:0], io_s[0]};
	wire [5:0] cnt_sum = bit_cnt + {3'h0, in_width};
	wire [7:0] op      = shift_next[7:0];

	wire op_quad_out  = (op == OP_QUAD_OUT) || (op == OP_QUAD_OUT_LONG);
	wire op_dual      = (op == OP_DUAL) || (op == OP_DUAL_LONG);
	wire op_quad      = (op == OP_QUAD) || (op == OP_QUAD_LONG);
	wire op_long      = (op == OP_QUAD_OUT_LONG) || (op == OP_DUAL_LONG) ||
		(op == OP_QUAD_LONG);
	wire quad_allowed = quad_enable_bit || quad_peripheral_enable_bit;
	wire op_ok        = quad_peripheral_mode_active ? (op_quad && quad_allowed) :
		(op_quad_out || op_quad) ? quad_allowed : op_dual;
	wire read_kind_t op_kind = op_dual ? RD_DUAL : (op_quad ? RD_QUAD : RD_QUAD_OUT);
	wire [5:0] addr_len = long_addr ? ADDR_BITS_LONG : ADDR_BITS_SHORT;
	wire [31:0] addr_word = long_addr ? shift_next : {8'h00, shift_next[23:0]};
	wire addr_done   = (state == ST_ADDR) && sck_rise && (cnt_sum == addr_len);
	wire dummy_done  = (state == ST_DUMMY) && sck_fall && (dcnt == latency_code_field);
	wire frame_read  = (state == ST_ADDR) || (state == ST_MODE) ||
		(state == ST_DUMMY) || (state == ST_DATA);

	// ---------------------------------------------------------------
	// Phase sequencing
	// ---------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_kind      = kind;
		next_bit_cnt   = bit_cnt;
		next_dcnt      = dcnt;
		next_long      = long_addr;
		next_pending   = pending;
		next_mode_done = mode_done;
		if (cs_s) begin
			next_state = ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					next_bit_cnt   = '0;
					next_dcnt      = '0;
					next_pending   = 1'b0;
					next_mode_done = 1'b0;
					next_kind      = cont_kind;
					next_state     = cont ? ST_ADDR : ST_CMD;
				end
				ST_CMD: begin
					if (sck_rise) begin
						next_bit_cnt = cnt_sum;
						if (cnt_sum == OPCODE_BITS) begin
							next_bit_cnt = '0;
							next_long    = op_long || address_length_bit;
							next_kind    = op_kind;
							next_state   = op_ok ? ST_ADDR : ST_IGNORE;
						end
					end
				end
				ST_ADDR: begin
					if (sck_rise) begin
						next_bit_cnt = cnt_sum;
						if (cnt_sum == addr_len) begin
							next_bit_cnt = '0;
							next_state = (kind == RD_QUAD_OUT) ? ST_DUMMY : ST_MODE;
						end
					end
				end
				ST_MODE: begin
					if (sck_rise) begin
						next_bit_cnt = cnt_sum;
						if (cnt_sum == MODE_BITS) begin
							// Only the upper nibble decides; the lower one may float.
							next_pending   = (shift_next[7:4] == CONT_NIBBLE);
							next_mode_done = 1'b1;
							next_state     = ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					// Lanes are not sampled here, so host drive is don't care.
					if (sck_fall) begin
						if (dcnt == latency_code_field) begin
							next_state = ST_DATA;
						end else begin
							next_dcnt = dcnt + 4'h1;
						end
					end
				end
				ST_DATA:   next_state = ST_DATA;
				ST_IGNORE: next_state = ST_IGNORE;
				default:   next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state     <= ST_IDLE;
			kind      <= RD_QUAD_OUT;
			bit_cnt   <= '0;
			dcnt      <= '0;
			long_addr <= 1'b0;
			pending   <= 1'b0;
			mode_done <= 1'b0;
		end else begin
			state     <= next_state;
			kind      <= next_kind;
			bit_cnt   <= next_bit_cnt;
			dcnt      <= next_dcnt;
			long_addr <= next_long;
			pending   <= next_pending;
			mode_done <= next_mode_done;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			shift <= '0;
		end else if (state == ST_IDLE) begin
			shift <= '0;
		end else if (sck_rise && (state == ST_CMD || state == ST_ADDR || state == ST_MODE)) begin
			shift <= shift_next;
		end
	end

	// ---------------------------------------------------------------
	// Continuous read mode
	// ---------------------------------------------------------------
	// A deselect that cuts a read short before its mode byte leaves the
	// mode undefined, so continuous mode is dropped in that case.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cont      <= 1'b0;
			cont_kind <= RD_DUAL;
		end else if (cs_rise && mode_done) begin
			cont      <= pending;
			cont_kind <= kind;
		end else if (cs_rise && frame_read) begin
			cont <= 1'b0;
		end else if (mode_reset_pulse) begin
			cont <= 1'b0;
		end
	end

	assign continuous_mode = cont;

	// ---------------------------------------------------------------
	// Data return
	// ---------------------------------------------------------------
	addr_step_if #(.ADDR_BITS(ARRAY_ADDR_BITS)) aif ();

	addr_counter #(.ADDR_BITS(ARRAY_ADDR_BITS)) u_addr_counter (
		.clock (clock),
		.rstn  (rstn),
		.aif   (aif.counter)
	);

	wire       data_fall = (state == ST_DATA) && sck_fall;
	wire       reload    = dummy_done || (data_fall && out_left == 4'h0);
	wire [7:0] out_src   = reload ? mem_rdata : out_sh;
	wire [3:0] out_w     = (kind == RD_DUAL) ? 4'h2 : 4'h4;
	wire [3:0] next_unit = (kind == RD_DUAL) ? {2'b00, out_src[7:6]} : out_src[7:4];
	wire [7:0] next_sh   = (kind == RD_DUAL) ? {out_src[5:0], 2'b00} : {out_src[3:0], 4'h0};
	wire [3:0] next_left = (reload ? BYTE_BITS : out_left) - out_w;

	assign aif.load       = addr_done;
	assign aif.load_value = addr_word[ARRAY_ADDR_BITS-1:0];
	assign aif.step       = reload;
	assign mem_addr       = aif.addr;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_lanes_out  <= '0;
			data_lanes_oe_n <= OE_OFF;
			out_sh          <= '0;
			out_left        <= '0;
		end else if (cs_s) begin
			data_lanes_oe_n <= OE_OFF;
		end else if (dummy_done || data_fall) begin
			data_lanes_out  <= next_unit;
			data_lanes_oe_n <= (kind == RD_DUAL) ? OE_DUAL : OE_QUAD;
			out_sh          <= next_sh;
			out_left        <= next_left;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			read_active <= 1'b0;
		end else begin
			read_active <= (next_state == ST_DATA);
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_dummy_end;
		state == ST_DUMMY && sck_fall && dcnt == latency_code_field;
	endsequence

	sequence s_quad_refused;
		state == ST_CMD && sck_rise && cnt_sum == OPCODE_BITS &&
			(op_quad || op_quad_out) && !quad_allowed;
	endsequence

	sequence s_cont_kept;
		cs_rise && mode_done && pending;
	endsequence

	a_quad_gate_off: assert property (s_quad_refused |=> state == ST_IGNORE)
		else $error("quad read taken while quad lanes disabled");

	a_dummy_then_data: assert property (s_dummy_end |=>
		state == ST_DATA && data_lanes_oe_n != OE_OFF)
		else $error("data did not start after the latency count");

	a_lanes_quiet_early: assert property (state != ST_DATA |-> data_lanes_oe_n == OE_OFF)
		else $error("lanes driven outside data return");

	a_deselect_release: assert property (cs_s |=>
		data_lanes_oe_n == OE_OFF && !read_active)
		else $error("lanes still driven after deselect");

	a_fall_edge_only: assert property (data_lanes_out != $past(data_lanes_out) |->
		$past(sck_fall))
		else $error("data lanes changed away from a falling edge");

	a_dual_two_lanes: assert property (state == ST_DATA && kind == RD_DUAL |->
		data_lanes_oe_n == OE_DUAL)
		else $error("dual read not driving exactly two lanes");

	a_cont_entry: assert property (s_cont_kept |=>
		cont ##1 (cont || $past(mode_reset_pulse)))
		else $error("continuous mode not kept after mode nibble A");

	a_cont_skip_cmd: assert property (state == ST_IDLE && !cs_s && cont |=>
		state == ST_ADDR && kind == cont_kind)
		else $error("continuous frame did not start with the address");

	a_cont_exit: assert property (cs_rise && mode_done && !pending |=> !cont)
		else $error("continuous mode kept after non-A mode nibble");

	a_mode_reset_exit: assert property (mode_reset_pulse && !cs_rise |=> !cont)
		else $error("mode reset did not leave continuous mode");

	a_mode_to_dummy: assert property (state == ST_MODE && sck_rise && cnt_sum == MODE_BITS |=>
		state == ST_DUMMY && dcnt == 4'h0 && mode_done)
		else $error("mode bits not followed by latency count");
endmodule : multi_io_flash_read

`default_nettype wire

/* logic/pin_sync.sv */
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to clock; only the second stage is used.
`default_nettype none

module pin_sync #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rstn,
	// Pins and synchronised copy
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			stage1 <= RESET_VALUE;
			q      <= RESET_VALUE;
		end else begin
			stage1 <= pin;
			q      <= stage1;
		end
	end
endmodule : pin_sync

`default_nettype wire

/* verif/multi_io_flash_read_tb.sv */
// Self-checking bench for the multi-lane flash read front end.
// Assumes the host model and a small array model sit at the far side.
`default_nettype none

module multi_io_flash_read_tb
	import mio_read_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] OPS [6] = '{OP_QUAD_OUT, OP_QUAD_OUT_LONG, OP_DUAL, OP_DUAL_LONG,
		OP_QUAD, OP_QUAD_LONG};
	localparam int AWS [3] = '{1, 2, 4};
	localparam int DWS [3] = '{4, 2, 4};
	logic       clock, rstn, sck, cs_n, alb, qe, qpe, qpm, mrst, cont, active;
	logic [3:0] lanes, lanes_out, oe_n, lat;
	logic [7:0] mem_addr, mem_rdata, rx_byte, key;
	int         rx_count, early, miscompares, num_checks, active_cycles;
	logic [7:0] exp_q [$];

	// The key is an argument so the array model follows it when it changes.
	function automatic logic [7:0] memval(input logic [7:0] a, input logic [7:0] k);
		return 8'(a * 8'h1d) ^ k;
	endfunction : memval
	assign mem_rdata = memval(mem_addr, key);

	// Counts the clocks in which the block reports a read in data return.
	always @(posedge clock) active_cycles <= active_cycles + int'(active);

	multi_io_flash_read #(.ARRAY_ADDR_BITS(8)) multi_io_flash_read_i (.clock(clock),
		.rstn(rstn), .sck(sck), .cs_n(cs_n), .data_lanes_in(lanes),
		.data_lanes_out(lanes_out), .data_lanes_oe_n(oe_n), .address_length_bit(alb),
		.quad_enable_bit(qe), .quad_peripheral_enable_bit(qpe),
		.quad_peripheral_mode_active(qpm), .latency_code_field(lat), .mode_reset_pulse(mrst),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .continuous_mode(cont),
		.read_active(active));
	spi_host_model spi_host_model_i (.clock(clock), .sck(sck), .cs_n(cs_n), .lanes(lanes),
		.dev_out(lanes_out), .dev_oe_n(oe_n), .rx_byte(rx_byte), .rx_count(rx_count),
		.early(early));

	// ---------------------------------------------------------------
	// Checking
	// ---------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] want);
		num_checks++;
		if (got !== want) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, want);
		end
	endtask : check

	task automatic finish_test();
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// Notes the expected bytes, runs one frame, then checks the lanes are let go.
	task automatic run(input logic [7:0] op, input int ow, input int abits, input int aw,
		input int dw, input logic [3:0] up, input logic [31:0] a, input int n);
		int act0;
		@(negedge clock);
		lat = 4'($urandom_range(3, 0));
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(memval(a[7:0] + 8'(i), key));
		end
		act0 = active_cycles;
		spi_host_model_i.frame(op, ow, a, abits, aw, {up, 4'($urandom)}, (dw == aw) ? aw : 0,
			int'(lat), dw, n);
		repeat (6) @(negedge clock);
		check(8'(active_cycles > act0), 8'(n > 0));
		check(8'(oe_n), 8'h0f);
		check(8'(active), 8'h00);
	endtask : run

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial forever begin
		@(rx_count);
		if (exp_q.size() == 0) begin
			miscompares++;
			$display("BAD %0t byte returned with none expected", $time);
		end else begin
			check(rx_byte, exp_q.pop_front());
		end
	end

	initial begin
		#600_000;
		miscompares++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		{rstn, alb, qpe, qpm, mrst} = 5'h00;
		qe = 1'b1;
		lat = 4'h0;
		key = 8'($urandom(49032));
		repeat (4) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		for (int k = 0; k < 3; k++) begin
			for (int v = 0; v < 3; v++) begin
				alb = (v == 2);
				run(OPS[2 * k + int'(v == 1)], 1, (v == 0) ? 24 : 32, AWS[k], DWS[k], 4'h3,
					$urandom, 3);
			end
		end
		alb = 1'b0;
		for (int k = 1; k < 3; k++) begin
			run(OPS[2 * k], 1, 24, AWS[k], DWS[k], 4'ha, $urandom, 2);
			check(8'(cont), 8'h01);
			run(8'h00, 0, 24, AWS[k], DWS[k], 4'ha, $urandom, 2);
			check(8'(cont), 8'h01);
			run(8'h00, 0, 24, AWS[k], DWS[k], 4'h5, $urandom, 2);
			check(8'(cont), 8'h00);
		end
		run(OP_QUAD, 1, 24, 4, 4, 4'ha, $urandom, 1);
		mrst = 1'b1;
		@(negedge clock);
		mrst = 1'b0;
		repeat (3) @(negedge clock);
		check(8'(cont), 8'h00);
		run(OP_QUAD, 1, 24, 4, 4, 4'h0, $urandom, 2);
		qe = 1'b0;
		spi_host_model_i.frame(OP_QUAD, 1, $urandom, 24, 4, 8'h00, 4, 6, 4, 0);
		run(OP_DUAL, 1, 24, 2, 2, 4'h0, $urandom, 2);
		qpe = 1'b1;
		run(OP_QUAD_OUT, 1, 24, 1, 4, 4'h0, $urandom, 2);
		qpm = 1'b1;
		run(OP_QUAD, 4, 24, 4, 4, 4'h0, $urandom, 2);
		qpm = 1'b0;
		run(OP_QUAD, 1, 24, 4, 4, 4'h0, 32'h0000_00fd, 6);
		// Six bytes from fd step the counter past the top and on to 03.
		check(mem_addr, 8'h03);
		check(8'(early), 8'h00);
		check(8'(exp_q.size()), 8'h00);
		finish_test();
	end
endmodule : multi_io_flash_read_tb

`default_nettype wire

/* verif/spi_host_model.sv */
// Host controller model: frames reads on the serial pins and collects returned bytes.
// Assumes its tasks are called from a process aligned to the falling system clock edge.
`default_nettype none

module spi_host_model (
	// Clock
	input  wire logic       clock,
	// Serial pins
	output logic            sck,
	output logic            cs_n,
	output logic [3:0]      lanes,
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe_n,
	// Returned data
	output logic [7:0]      rx_byte,
	output var int          rx_count,
	output var int          early
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 5;
	logic [3:0] drive;
	logic [3:0] host_en;
	logic       filler = 1'b0;

	// ---------------------------------------------------------------
	// Wire levels
	// ---------------------------------------------------------------
	// Lanes that nobody drives toggle every clock, so stale values cannot pass.
	assign lanes = (~dev_oe_n & dev_out) | (dev_oe_n & host_en & drive)
		| (dev_oe_n & ~host_en & {4{filler}});
	always @(posedge clock) filler <= ~filler;

	initial begin
		sck      = 1'b0;
		cs_n     = 1'b1;
		drive    = 4'h0;
		host_en  = 4'h0;
		rx_byte  = 8'h00;
		rx_count = 0;
		early    = 0;
	end

	// ---------------------------------------------------------------
	// Serial cycles
	// ---------------------------------------------------------------
	// One SCK period: drive after the fall, sample just before the rise.
	task automatic cycle(input logic [3:0] val, input logic [3:0] en, output logic [3:0] seen);
		@(negedge clock);
		sck     = 1'b0;
		drive   = val;
		host_en = en;
		repeat (HALF) @(negedge clock);
		seen = lanes;
		sck  = 1'b1;
		repeat (HALF - 1) @(negedge clock);
	endtask : cycle

	task automatic shift(input logic [31:0] val, input int nbits, input int width);
		logic [3:0] seen;
		for (int k = nbits - width; k >= 0; k -= width) begin
			cycle(4'((val >> k) & ((1 << width) - 1)), 4'((1 << width) - 1), seen);
		end
	endtask : shift

	task automatic frame(input logic [7:0] op, input int ow, input logic [31:0] addr,
		input int abits, input int aw, input logic [7:0] mode, input int mw,
		input int dummies, input int dw, input int nbytes);
		logic [3:0] seen;
		logic [7:0] acc;
		acc = 8'h00;
		@(negedge clock);
		cs_n = 1'b0;
		repeat (3) @(negedge clock);
		if (ow > 0) begin
			shift(32'(op), 8, ow);
		end
		shift(addr, abits, aw);
		if (mw > 0) begin
			shift(32'(mode), 8, mw);
		end
		repeat (dummies) begin
			cycle(4'h0, 4'h0, seen);
			if (dev_oe_n !== 4'hf) begin
				early++;
			end
		end
		for (int b = 0; b < nbytes * 8 / dw; b++) begin
			cycle(4'h0, 4'h0, seen);
			acc = (acc << dw) | 8'(seen & 4'((1 << dw) - 1));
			if ((b + 1) % (8 / dw) == 0) begin
				rx_byte = acc;
				rx_count++;
			end
		end
		@(negedge clock);
		cs_n    = 1'b1;
		host_en = 4'h0;
		repeat (HALF) @(negedge clock);
		sck = 1'b0;
		repeat (HALF) @(negedge clock);
	endtask : frame
endmodule : spi_host_model

`default_nettype wire
